// [logic/alu_pkg.sv]
// Constants and types for the accumulator add and bit datapath
// Function
// - add_literal adds 8-bit literal to accumulator; updates carry, nibble, zero.
// - add_acc_reg adds file register at 7-bit address; updates carry, nibble, zero.
// - Add/AND register ops: destination 0 writes accumulator, 1 writes file register.
// - and_acc_reg ANDs accumulator with file register; only zero flag changes.
// - and_literal ANDs accumulator with literal into accumulator; only zero flag.
// - bit_clear_reg clears indexed bit of file register; flags unchanged.
// - bit_set_reg sets indexed bit of file register; flags unchanged.
`default_nettype none
package alu_pkg;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BIT_W      = 3;
  localparam int BUS_AW     = 8;
  localparam int NIB_W      = 4;
  localparam int FLAG_W     = 3;

  // Register map on the software port
  localparam logic [7:0] FILE_BASE = 8'h00;
  localparam logic [7:0] FILE_LAST = 8'h7F;
  localparam logic [7:0] ACC_ADDR  = 8'h80;
  localparam logic [7:0] STAT_ADDR = 8'h81;
  localparam logic [7:0] STATE_ADDR = 8'h82;
  localparam logic [7:0] COUNT_ADDR = 8'h83;

  // Status and state register bit positions
  localparam int CARRY_POS  = 0;
  localparam int NIBBLE_POS = 1;
  localparam int ZERO_POS   = 2;
  localparam int BUSY_POS   = 0;

  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [2:0] FLAG_RST  = 3'h0;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic       DEST_ACC  = 1'b0;

  typedef enum logic [2:0] {
    OP_ADD_LIT = 3'b000,
    OP_ADD_REG = 3'b001,
    OP_AND_REG = 3'b010,
    OP_AND_LIT = 3'b011,
    OP_BIT_CLR = 3'b100,
    OP_BIT_SET = 3'b101
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } state_t;
endpackage
`default_nettype wire

// [logic/file_port_if.sv]
// Port bundle between the datapath and its file register memory
`default_nettype none
interface file_port_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic [AW-1:0] core_addr;
  logic [DW-1:0] core_data;
  logic          bus_rd;
  logic [AW-1:0] bus_addr;
  logic          bus_ext;
  logic [DW-1:0] bus_ext_data;
  logic [DW-1:0] bus_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;

  modport ctrl (
    output core_addr, bus_rd, bus_addr, bus_ext, bus_ext_data,
    output wr_en, wr_addr, wr_data,
    input  core_data, bus_data
  );
  modport mem (
    input  core_addr, bus_rd, bus_addr, bus_ext, bus_ext_data,
    input  wr_en, wr_addr, wr_data,
    output core_data, bus_data
  );
endinterface
`default_nettype wire

// [logic/file_mem.sv]
// File register memory: one write port, two registered read ports
`default_nettype none
module file_mem
  import alu_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int DW    = 8
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  file_port_if.mem   port
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] core_data_r;
  logic [DW-1:0] bus_data_r;

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_data_r <= DATA_ZERO;
    end else begin
      core_data_r <= mem_r[port.core_addr];
    end
  end

  // Bus read register also carries non-memory words; zero when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_r <= DATA_ZERO;
    end else if (!port.bus_rd) begin
      bus_data_r <= DATA_ZERO;
    end else if (port.bus_ext) begin
      bus_data_r <= port.bus_ext_data;
    end else begin
      bus_data_r <= mem_r[port.bus_addr];
    end
  end

  assign port.core_data = core_data_r;
  assign port.bus_data  = bus_data_r;
endmodule
`default_nettype wire

// [logic/acc_alu.sv]
// Accumulator add, AND and bit set/clear datapath with register port
`default_nettype none
module acc_alu
  import alu_pkg::*;
#(
  parameter int DEPTH = FILE_DEPTH
) (
  input  wire logic                CORE_CLK,
  input  wire logic                RSTN,
  input  wire logic [BUS_AW-1:0]   REG_ADDR,
  input  wire logic [DATA_W-1:0]   REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic      [DATA_W-1:0]   REG_RDATA,
  input  wire logic                INS_VALID,
  input  wire logic [2:0]          INS_OP,
  input  wire logic [DATA_W-1:0]   INS_LIT,
  input  wire logic [FADDR_W-1:0]  INS_FADDR,
  input  wire logic                INS_DEST,
  input  wire logic [BIT_W-1:0]    INS_BIT,
  output logic                     INS_READY,
  output logic                     INS_DONE,
  output logic      [DATA_W-1:0]   ACC_OUT,
  output logic      [FLAG_W-1:0]   FLAGS_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  file_port_if #(.AW(FADDR_W), .DW(DATA_W)) fport ();

  state_t              state_r;
  state_t              state_nxt;
  logic [DATA_W-1:0]   acc_r;
  logic [DATA_W-1:0]   acc_nxt;
  logic                acc_we;
  logic                carry_r;
  logic                carry_nxt;
  logic                nib_r;
  logic                nib_nxt;
  logic                zero_r;
  logic                zero_nxt;
  logic                ready_r;
  logic                done_r;
  logic                done_nxt;
  logic [DATA_W-1:0]   count_r;

  // Instruction held while its file register is read
  op_t                 op_r;
  logic [FADDR_W-1:0]  faddr_r;
  logic                dest_r;
  logic [BIT_W-1:0]    bit_r;

  logic                accept;
  logic                needs_file;
  op_t                 op_in;
  logic                known_op;

  // Execution result
  logic [DATA_W-1:0]   operand;
  logic [DATA_W:0]     sum_full;
  logic [NIB_W:0]      sum_nib;
  logic [DATA_W-1:0]   result;
  logic [DATA_W-1:0]   bit_mask;
  logic                file_we;
  op_t                 op_exec;
  logic                exec_now;

  // Software port decode
  logic                bus_file;
  logic                bus_acc_wr;
  logic                bus_stat_wr;
  logic [DATA_W-1:0]   ext_data;
  logic [DATA_W-1:0]   stat_word;
  logic [DATA_W-1:0]   state_word;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction acceptance

  assign op_in      = op_t'(INS_OP);
  assign accept     = INS_VALID && ready_r;
  assign needs_file = (op_in == OP_ADD_REG) || (op_in == OP_AND_REG) ||
                      (op_in == OP_BIT_CLR) || (op_in == OP_BIT_SET);
  assign known_op   = needs_file || (op_in == OP_ADD_LIT) ||
                      (op_in == OP_AND_LIT);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept && needs_file) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == ST_IDLE);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      op_r    <= OP_ADD_LIT;
      faddr_r <= '0;
      dest_r  <= DEST_ACC;
      bit_r   <= '0;
    end else if (accept) begin
      op_r    <= op_in;
      faddr_r <= INS_FADDR;
      dest_r  <= INS_DEST;
      bit_r   <= INS_BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  // Literal ops execute on acceptance, file ops one cycle later
  assign exec_now = (state_r == ST_EXEC) ||
                    (accept && known_op && !needs_file);
  assign op_exec  = (state_r == ST_EXEC) ? op_r : op_in;

  always_comb begin
    if (state_r == ST_EXEC) begin
      operand = fport.core_data;
    end else begin
      operand = INS_LIT;
    end
  end

  assign sum_full = {1'b0, acc_r} + {1'b0, operand};
  assign sum_nib  = {1'b0, acc_r[NIB_W-1:0]} +
                    {1'b0, operand[NIB_W-1:0]};
  assign bit_mask = DATA_W'(1) << bit_r;

  always_comb begin
    result    = DATA_ZERO;
    carry_nxt = carry_r;
    nib_nxt   = nib_r;
    zero_nxt  = zero_r;
    if (exec_now) begin
      case (op_exec)
        OP_ADD_LIT, OP_ADD_REG: begin
          result    = sum_full[DATA_W-1:0];
          carry_nxt = sum_full[DATA_W];
          nib_nxt   = sum_nib[NIB_W];
          zero_nxt  = (sum_full[DATA_W-1:0] == DATA_ZERO);
        end
        OP_AND_LIT, OP_AND_REG: begin
          result    = acc_r & operand;
          zero_nxt  = ((acc_r & operand) == DATA_ZERO);
        end
        OP_BIT_CLR: begin
          result = operand & ~bit_mask;
        end
        OP_BIT_SET: begin
          result = operand | bit_mask;
        end
        default: begin
          result = DATA_ZERO;
        end
      endcase
    end
  end

  // Destination select; bit ops always return to the file register
  always_comb begin
    acc_we  = 1'b0;
    file_we = 1'b0;
    if (exec_now) begin
      case (op_exec)
        OP_ADD_LIT, OP_AND_LIT: begin
          acc_we = 1'b1;
        end
        OP_ADD_REG, OP_AND_REG: begin
          acc_we  = (dest_r == DEST_ACC);
          file_we = (dest_r != DEST_ACC);
        end
        OP_BIT_CLR, OP_BIT_SET: begin
          file_we = 1'b1;
        end
        default: begin
          acc_we = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software port decode

  assign bus_file    = (REG_ADDR <= FILE_LAST);
  assign bus_acc_wr  = REG_WR && (REG_ADDR == ACC_ADDR);
  assign bus_stat_wr = REG_WR && (REG_ADDR == STAT_ADDR);

  assign stat_word  = {5'h0_0, zero_r, nib_r, carry_r};
  assign state_word = {7'h0_0, (state_r == ST_EXEC)};

  always_comb begin
    case (REG_ADDR)
      ACC_ADDR:   ext_data = acc_r;
      STAT_ADDR:  ext_data = stat_word;
      STATE_ADDR: ext_data = state_word;
      COUNT_ADDR: ext_data = count_r;
      default:    ext_data = DATA_ZERO;
    endcase
  end

  // Core write has priority over a software write in the same cycle
  always_comb begin
    acc_nxt = acc_r;
    if (acc_we) begin
      acc_nxt = result;
    end else if (bus_acc_wr) begin
      acc_nxt = REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_r <= ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Flags: an instruction update beats a software write
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      carry_r <= FLAG_RST[CARRY_POS];
      nib_r   <= FLAG_RST[NIBBLE_POS];
      zero_r  <= FLAG_RST[ZERO_POS];
    end else if (exec_now) begin
      carry_r <= carry_nxt;
      nib_r   <= nib_nxt;
      zero_r  <= zero_nxt;
    end else if (bus_stat_wr) begin
      carry_r <= REG_WDATA[CARRY_POS];
      nib_r   <= REG_WDATA[NIBBLE_POS];
      zero_r  <= REG_WDATA[ZERO_POS];
    end
  end

  assign done_nxt = exec_now;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  // Completed-instruction counter; software write reloads it unless an instruction completes in the same cycle
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_r <= DATA_ZERO;
    end else if (exec_now) begin
      count_r <= count_r + COUNT_ONE;
    end else if (REG_WR && (REG_ADDR == COUNT_ADDR)) begin
      count_r <= REG_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register memory

  assign fport.core_addr    = INS_FADDR;
  assign fport.bus_rd       = REG_RD;
  assign fport.bus_addr     = REG_ADDR[FADDR_W-1:0];
  assign fport.bus_ext      = !bus_file;
  assign fport.bus_ext_data = ext_data;
  assign fport.wr_en        = file_we || (REG_WR && bus_file);
  assign fport.wr_addr      = file_we ? faddr_r : REG_ADDR[FADDR_W-1:0];
  assign fport.wr_data      = file_we ? result : REG_WDATA;

  file_mem #(
    .DEPTH (DEPTH),
    .DW    (DATA_W)
  ) u_file_mem (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .port  (fport)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign REG_RDATA = fport.bus_data;
  assign INS_READY = ready_r;
  assign INS_DONE  = done_r;
  assign ACC_OUT   = acc_r;
  assign FLAGS_OUT = {zero_r, nib_r, carry_r};

endmodule
`default_nettype wire

// [tb/acc_alu_sva.sv]
// Instruction-side assertions for the datapath
`default_nettype none
module acc_alu_sva
  import alu_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  input wire logic       INS_VALID,
  input wire logic [2:0] INS_OP,
  input wire logic [7:0] INS_LIT,
  input wire logic       INS_DEST,
  input wire logic       INS_READY,
  input wire logic       INS_DONE,
  input wire logic [7:0] ACC_OUT,
  input wire logic [2:0] FLAGS_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic       tk;
  logic       rop;
  logic [8:0] sum;
  logic [4:0] nib;
  assign tk  = INS_VALID && INS_READY;
  assign rop = INS_OP == 3'b001 || INS_OP == 3'b010;
  assign sum = {1'b0, ACC_OUT} + {1'b0, INS_LIT};
  assign nib = {1'b0, ACC_OUT[3:0]} + {1'b0, INS_LIT[3:0]};
  property p_add_lit;
    tk && INS_OP == 3'b000 |=> INS_DONE && ACC_OUT == $past(sum[7:0]);
  endproperty
  a_add_lit: assert property (p_add_lit)
    else $error("add literal result");
  property p_add_flags;
    tk && INS_OP == 3'b000 |=>
      FLAGS_OUT == $past({sum[7:0] == 8'h00, nib[4], sum[8]});
  endproperty
  a_add_flags: assert property (p_add_flags)
    else $error("add literal flags");
  property p_and_lit;
    tk && INS_OP == 3'b011 |=> ACC_OUT == $past(ACC_OUT & INS_LIT)
      && FLAGS_OUT == {ACC_OUT == 8'h00, $past(FLAGS_OUT[1:0])};
  endproperty
  a_and_lit: assert property (p_and_lit)
    else $error("and literal");
  property p_file_lat;
    tk && INS_OP inside {3'b001, 3'b010, 3'b100, 3'b101}
      |=> !INS_READY && !INS_DONE ##1 INS_DONE;
  endproperty
  a_file_lat: assert property (p_file_lat)
    else $error("file op timing");
  property p_and_reg;
    tk && INS_OP == 3'b010 |=> ##1 FLAGS_OUT[1:0] == $past(FLAGS_OUT[1:0], 2);
  endproperty
  a_and_reg: assert property (p_and_reg)
    else $error("and register flags");
  property p_dest_reg;
    tk && rop && INS_DEST |=> ##1 ACC_OUT == $past(ACC_OUT, 2);
  endproperty
  a_dest_reg: assert property (p_dest_reg)
    else $error("register destination");
  property p_bit_clr;
    tk && INS_OP == 3'b100 |=> ($stable(FLAGS_OUT) && $stable(ACC_OUT))[*2];
  endproperty
  a_bit_clr: assert property (p_bit_clr)
    else $error("bit clear flags");
  property p_bit_set;
    tk && INS_OP == 3'b101 |=> ##1 INS_DONE && FLAGS_OUT == $past(FLAGS_OUT, 2);
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("bit set flags");
endmodule
bind acc_alu acc_alu_sva u_sva (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .INS_VALID(INS_VALID),
  .INS_OP(INS_OP), .INS_LIT(INS_LIT), .INS_DEST(INS_DEST),
  .INS_READY(INS_READY), .INS_DONE(INS_DONE), .ACC_OUT(ACC_OUT),
  .FLAGS_OUT(FLAGS_OUT)
);
`default_nettype wire

// [tb/ins_src.sv]
// Instruction source standing in for the decoder
`default_nettype none
module ins_src (
  input  wire logic       clk,
  input  wire logic       ready,
  output logic            valid,
  output logic [2:0]      op,
  output logic [7:0]      lit,
  output logic [6:0]      faddr,
  output logic            dest,
  output logic [2:0]      bidx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid = 1'b0;
    op    = 3'h0;
    lit   = 8'h00;
    faddr = 7'h00;
    dest  = 1'b0;
    bidx  = 3'h0;
  end
  // Holds the offer until taken or for at most 8 cycles, then scrambles the operands
  task automatic issue(input logic [2:0] o, input logic [7:0] k,
                       input logic [6:0] f, input logic d,
                       input logic [2:0] b);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    op    <= o;
    lit   <= k;
    faddr <= f;
    dest  <= d;
    bidx  <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 8);
    valid <= 1'b0;
    lit   <= ~k;
    faddr <= ~f;
    bidx  <= ~b;
  endtask
endmodule
`default_nettype wire

// [tb/acc_alu_bench.sv]
// Self-checking bench for the accumulator datapath
`default_nettype none
module acc_alu_bench
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       CORE_CLK = 1'b0;
  logic       RSTN = 1'b0;
  logic       REG_WR = 1'b0;
  logic       REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA, INS_LIT, ACC_OUT;
  logic [6:0] INS_FADDR;
  logic [2:0] INS_OP, INS_BIT, FLAGS_OUT;
  logic       INS_VALID, INS_DEST, INS_READY, INS_DONE;
  int         num_errors = 0;
  int         n_checks = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  acc_alu u_dut (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .INS_VALID(INS_VALID), .INS_OP(INS_OP),
    .INS_LIT(INS_LIT), .INS_FADDR(INS_FADDR), .INS_DEST(INS_DEST),
    .INS_BIT(INS_BIT), .INS_READY(INS_READY), .INS_DONE(INS_DONE),
    .ACC_OUT(ACC_OUT), .FLAGS_OUT(FLAGS_OUT)
  );
  ins_src u_src (
    .clk(CORE_CLK), .ready(INS_READY), .valid(INS_VALID), .op(INS_OP),
    .lit(INS_LIT), .faddr(INS_FADDR), .dest(INS_DEST), .bidx(INS_BIT)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes rise and fall on rising edges; results read at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(negedge CORE_CLK);
    chk(REG_RDATA, exp);
  endtask
  task automatic run(input logic [2:0] o, input logic [7:0] k,
                     input logic [6:0] f, input logic d,
                     input logic [2:0] b);
    int n;
    u_src.issue(o, k, f, d, b);
    n = 0;
    @(negedge CORE_CLK);
    while (INS_DONE !== 1'b1 && n < 4) begin
      @(negedge CORE_CLK);
      n++;
    end
    chk({7'h00, INS_DONE}, 8'h01);
  endtask
  function automatic logic [7:0] addf(input logic [7:0] a, input logic [7:0] k);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, k};
    h = {1'b0, a[3:0]} + {1'b0, k[3:0]};
    return {5'h00, s[7:0] == 8'h00, h[4], s[8]};
  endfunction
  task automatic t_add_lit;
    logic [7:0] av[3] = '{8'hF8, 8'h00, 8'h3C};
    logic [7:0] kv[3] = '{8'h08, 8'hFF, 8'h45};
    for (int i = 0; i < 3; i++) begin
      wr(ACC_ADDR, av[i]);
      run(3'b000, kv[i], 7'h00, 1'b0, 3'h0);
      chk(ACC_OUT, av[i] + kv[i]);
      chk({5'h00, FLAGS_OUT}, addf(av[i], kv[i]));
    end
    $display("add literal test done");
  endtask
  task automatic t_and_lit;
    wr(STAT_ADDR, 8'h03);
    wr(ACC_ADDR, 8'hF0);
    run(3'b011, 8'h0F, 7'h00, 1'b0, 3'h0);
    chk({5'h00, FLAGS_OUT}, 8'h07);
    wr(ACC_ADDR, 8'h5A);
    run(3'b011, 8'hC3, 7'h00, 1'b0, 3'h0);
    chk(ACC_OUT, 8'h42);
    chk({5'h00, FLAGS_OUT}, 8'h03);
    $display("and literal test done");
  endtask
  task automatic t_add_reg;
    wr(8'h7F, 8'h99);
    wr(ACC_ADDR, 8'h88);
    run(3'b001, 8'h00, 7'h7F, 1'b0, 3'h0);
    chk(ACC_OUT, 8'h21);
    chk({5'h00, FLAGS_OUT}, addf(8'h88, 8'h99));
    wr(8'h00, 8'h10);
    run(3'b001, 8'h00, 7'h00, 1'b1, 3'h0);
    chk(ACC_OUT, 8'h21);
    run(3'b001, 8'h00, 7'h00, 1'b0, 3'h0);
    chk(ACC_OUT, 8'h52);
    rdc(ACC_ADDR, 8'h52);
    rdc(8'h00, 8'h31);
    $display("add register test done");
  endtask
  task automatic t_and_reg;
    wr(8'h12, 8'h0F);
    wr(8'h13, 8'hAD);
    wr(STAT_ADDR, 8'h03);
    run(3'b010, 8'h00, 7'h12, 1'b1, 3'h0);
    rdc(8'h12, 8'h02);
    run(3'b010, 8'h00, 7'h12, 1'b0, 3'h0);
    run(3'b010, 8'h00, 7'h13, 1'b0, 3'h0);
    chk(ACC_OUT, 8'h00);
    chk({5'h00, FLAGS_OUT}, 8'h07);
    $display("and register test done");
  endtask
  task automatic t_bits;
    wr(STAT_ADDR, 8'h05);
    wr(8'h40, 8'h00);
    for (int i = 0; i < 8; i++) run(3'b101, 8'h00, 7'h40, 1'b1, 3'(i));
    rdc(8'h40, 8'hFF);
    for (int i = 0; i < 4; i++) run(3'b100, 8'h00, 7'h40, 1'b0, 3'(2 * i));
    rdc(8'h40, 8'hAA);
    chk({5'h00, FLAGS_OUT}, 8'h05);
    rdc(STAT_ADDR, 8'h05);
    $display("bit test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(negedge CORE_CLK);
    chk(ACC_OUT, ACC_RST);
    rdc(8'hA0, 8'h00);
    t_add_lit();
    t_and_lit();
    t_add_reg();
    t_and_reg();
    t_bits();
    tally_and_finish();
  end
endmodule
`default_nettype wire
